// ---- core/sdrc_pkg.sv ----
// Package of constants for the synthesizer reference and divider control block.
package sdrc_pkg;

   // Clock rate and regulator start-up time.
   localparam int CLK_FREQ_MHZ = 50;
   localparam int REG_UP_TIME_US = 50;
   localparam int REG_UP_CYCLES = REG_UP_TIME_US * CLK_FREQ_MHZ;
   localparam logic [11:0] REG_UP_COUNT = 12'(REG_UP_CYCLES);

   // Register port addresses.
   localparam logic [1:0] ADDR_LATCH0 = 2'h0;
   localparam logic [1:0] ADDR_LATCH1 = 2'h1;
   localparam logic [1:0] ADDR_STATUS = 2'h2;

   // Serial word length and latch control codes in the two low bits.
   localparam int SER_BITS = 32;
   localparam int NUM_LATCH = 2;

   // Field positions of latch 0.
   localparam int R0_FRAC_LSB = 2;
   localparam int R0_INT_LSB = 16;
   localparam int R0_PLL_EN_BIT = 28;
   localparam int R0_MUX_LSB = 29;

   // Field positions of latch 1.
   localparam int R1_RDIV_LSB = 4;
   localparam int R1_CLKDIV_LSB = 8;
   localparam int R1_OSC_EN_BIT = 12;
   localparam int R1_DIV2_BIT = 13;
   localparam int R1_BIAS_LSB = 16;
   localparam int R1_VADJ_LSB = 20;

   // Reset values: R = 1, clock output divide field 4 (ratio 8), oscillator on, mux on regulator ready.
   localparam logic [31:0] R0_RESET = 32'h0000_0000;
   localparam logic [31:0] R1_RESET = 32'h0000_1411;

   // Diagnostic multiplexer source codes.
   localparam logic [2:0] MUX_REG_READY = 3'h0;
   localparam logic [2:0] MUX_DIG_LOCK = 3'h1;
   localparam logic [2:0] MUX_PLL_EN = 3'h2;
   localparam logic [2:0] MUX_PFD_TICK = 3'h3;
   localparam logic [2:0] MUX_LOGIC_LOW = 3'h4;
   localparam logic [2:0] MUX_LOGIC_HIGH = 3'h5;

   // Digital lock detect thresholds in nanoseconds and run length.
   localparam logic [7:0] LOCK_SET_NS = 8'h0F;
   localparam logic [7:0] LOCK_CLEAR_NS = 8'h19;
   localparam logic [2:0] LOCK_RUN = 3'h5;

   // Status word bit positions.
   localparam int ST_REG_READY = 0;
   localparam int ST_LOCK = 1;
   localparam int ST_CLK_DRIVE = 2;

   // Lock detector states.
   typedef enum logic {SDRC_SEARCH, SDRC_LOCKED} sdrc_lock_t;

endpackage

// ---- core/sdrc_div_if.sv ----
// Interface carrying the clock output divide setting and the divided clock back.
`timescale 1ns/1ps
interface sdrc_div_if;
   logic [3:0] div_k;    // Half-period in reference cycles, zero stops the output.
   logic clk_level;      // Divided clock level.
   logic drive;          // High while the output pin is driven.
   modport ctrl (output div_k, input clk_level, input drive);
   modport div (input div_k, output clk_level, output drive);
endinterface

// ---- core/sdrc_clkdiv.sv ----
// Even divider for the divided reference clock output.
`timescale 1ns/1ps
module sdrc_clkdiv
   import sdrc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   sdrc_div_if.div port
);

   logic [3:0] k_q;      // Setting in use.
   logic [3:0] cnt_q;    // Cycles spent in the current half period.
   logic lvl_q;          // Output level.

   // A change of setting restarts the output low with a cleared count, which can cut a high half period short.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         k_q <= 4'h0;
         cnt_q <= 4'h0;
         lvl_q <= 1'b0;
      end else if (port.div_k != k_q) begin
         k_q <= port.div_k;
         cnt_q <= 4'h0;
         lvl_q <= 1'b0;
      end else if (k_q == 4'h0) begin
         lvl_q <= 1'b0;
      end else if (cnt_q == k_q - 4'h1) begin
         cnt_q <= 4'h0;
         lvl_q <= ~lvl_q;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   assign port.clk_level = lvl_q;
   assign port.drive = (k_q != 4'h0);

   // Each half period lasts exactly k cycles while the setting holds.
   half_period_a: assert property (@(posedge clk) disable iff (rst)
      ($changed(lvl_q) && $past(k_q) == k_q && k_q != 4'h0) |-> ($past(cnt_q) == k_q - 4'h1))
      else $error("Divided clock toggled at the wrong count.");

   // A zero setting keeps the output quiet.
   stop_output_a: assert property (@(posedge clk) disable iff (rst)
      (k_q == 4'h0) |-> (!lvl_q && !port.drive))
      else $error("Divided clock active while stopped.");

endmodule

// ---- core/sdrc_top.sv ----
// Synthesizer reference, divider, lock detect and diagnostic mux control.
`timescale 1ns/1ps
module sdrc_top
   import sdrc_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic POWER_ON,
   input wire logic SCLK,
   input wire logic SDATA,
   input wire logic LATCH_LOAD_STROBE,
   input wire logic [7:0] PHASE_ERR_NS,
   input wire logic [1:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   output logic REGULATOR_ENABLE,
   output logic OSC_ENABLE,
   output logic DIVIDED_REF_CLOCK_OUT,
   output logic DIVIDED_REF_CLOCK_OE,
   output logic DIAG_MUX_OUT,
   output logic PLL_ENABLE,
   output logic VCO_ENABLE,
   output logic [1:0] VCO_ADJUST,
   output logic [3:0] VCO_BIAS,
   output logic LOW_BAND_DIV2,
   output logic [7:0] INT_DIVIDE,
   output logic [13:0] FRAC_DIVIDE,
   output logic PFD_TICK,
   output logic [8:0] FEEDBACK_DIVIDE
);

   // Returns one-hot write enables for the two latches from a two-bit latch code.
   function automatic logic [NUM_LATCH-1:0] latch_sel(input logic [1:0] code);
      logic [NUM_LATCH-1:0] sel;
      sel = '0;
      if (code == ADDR_LATCH0) begin
         sel[0] = 1'b1;
      end else if (code == ADDR_LATCH1) begin
         sel[1] = 1'b1;
      end
      return sel;
   endfunction

   logic [31:0] latch_q [NUM_LATCH];   // Programmed latches 0 and 1.
   logic [31:0] shift_q;               // Serial shift register.
   logic sclk_q;                       // Previous serial clock sample.
   logic strobe_q;                     // Previous load strobe sample.
   logic [11:0] reg_cnt_q;             // Regulator start-up timer.
   logic reg_ready_q;                  // Regulator at nominal voltage.
   logic [2:0] r_cnt_q;                // Reference divider count.
   logic pfd_tick_q;                   // One-cycle phase detector enable.
   logic [14:0] frac_acc_q;            // Sigma-delta accumulator with carry.
   logic [8:0] fb_div_q;               // Divide value for the current PFD cycle.
   sdrc_lock_t lock_state_q;           // Lock detector state.
   logic [2:0] lock_run_q;             // Consecutive good phase comparisons.
   logic osc_en_q;                     // Oscillator enable register.
   logic mux_q;                        // Registered diagnostic output.
   logic [31:0] rdata_q;               // Read data for the cycle after a read.
   logic [NUM_LATCH-1:0] ser_sel;      // Latch picked by the serial word.
   logic [NUM_LATCH-1:0] bus_sel;      // Latch picked by the register port.
   logic strobe_rise;                  // Load strobe rising edge.
   logic sclk_rise;                    // Serial clock rising edge.
   logic [2:0] r_div;                  // Effective R value.

   sdrc_div_if div_bus ();

   assign sclk_rise = SCLK && !sclk_q;
   assign strobe_rise = LATCH_LOAD_STROBE && !strobe_q;
   assign ser_sel = latch_sel(shift_q[1:0]);
   assign bus_sel = latch_sel(ADDR);

   // Edge history of the serial pins; inputs are already in the clock domain.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         sclk_q <= 1'b0;
         strobe_q <= 1'b0;
      end else begin
         sclk_q <= SCLK;
         strobe_q <= LATCH_LOAD_STROBE;
      end
   end

   // The shift register only runs once the interface regulator is ready, as it is unpowered before.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         shift_q <= 32'h0000_0000;
      end else if (!POWER_ON) begin
         shift_q <= 32'h0000_0000;
      end else if (reg_ready_q && sclk_rise) begin
         shift_q <= {shift_q[SER_BITS-2:0], SDATA};
      end
   end

   // One storage process per latch; the strobe wins over a port write in the same cycle.
   generate
      for (genvar g = 0; g < NUM_LATCH; g++) begin : g_latch
         localparam logic [31:0] RST_VAL = (g == 0) ? R0_RESET : R1_RESET;
         always_ff @(posedge CLOCK or posedge RST) begin
            if (RST) begin
               latch_q[g] <= RST_VAL;
            end else if (!POWER_ON) begin
               latch_q[g] <= RST_VAL;
            end else if (reg_ready_q && strobe_rise && ser_sel[g]) begin
               latch_q[g] <= shift_q;
            end else if (reg_ready_q && WR && bus_sel[g]) begin
               latch_q[g] <= WDATA;
            end
         end
      end
   endgenerate

   // Regulator start-up timer; it restarts whenever the power pin drops.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         reg_cnt_q <= 12'h000;
         reg_ready_q <= 1'b0;
      end else if (!POWER_ON) begin
         reg_cnt_q <= 12'h000;
         reg_ready_q <= 1'b0;
      end else if (reg_cnt_q == REG_UP_COUNT - 12'h001) begin
         reg_ready_q <= 1'b1;
      end else begin
         reg_cnt_q <= reg_cnt_q + 12'h001;
      end
   end

   // Oscillator enable, gated by the power pin.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         osc_en_q <= 1'b0;
      end else begin
         osc_en_q <= POWER_ON && latch_q[1][R1_OSC_EN_BIT];
      end
   end

   // A zero R field would stall the phase detector, so it acts as R = 1.
   assign r_div = (latch_q[1][R1_RDIV_LSB +: 3] == 3'h0) ? 3'h1 : latch_q[1][R1_RDIV_LSB +: 3];

   // Reference divider: one tick every R reference cycles while the oscillator runs.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         r_cnt_q <= 3'h0;
         pfd_tick_q <= 1'b0;
      end else if (!osc_en_q) begin
         r_cnt_q <= 3'h0;
         pfd_tick_q <= 1'b0;
      end else if (r_cnt_q >= r_div - 3'h1) begin
         r_cnt_q <= 3'h0;
         pfd_tick_q <= 1'b1;
      end else begin
         r_cnt_q <= r_cnt_q + 3'h1;
         pfd_tick_q <= 1'b0;
      end
   end

   // First-order sigma-delta: the fraction carry adds one to the integer for that PFD cycle.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         frac_acc_q <= 15'h0000;
         fb_div_q <= 9'h000;
      end else if (!latch_q[0][R0_PLL_EN_BIT]) begin
         frac_acc_q <= 15'h0000;
         fb_div_q <= {1'b0, latch_q[0][R0_INT_LSB +: 8]};
      end else if (pfd_tick_q) begin
         frac_acc_q <= {1'b0, frac_acc_q[13:0]} + {1'b0, latch_q[0][R0_FRAC_LSB +: 14]};
         fb_div_q <= {1'b0, latch_q[0][R0_INT_LSB +: 8]} + {8'h00, frac_acc_q[14]};
      end
   end

   // Digital lock detector, evaluated once per phase detector cycle.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         lock_state_q <= SDRC_SEARCH;
         lock_run_q <= 3'h0;
      end else if (!latch_q[0][R0_PLL_EN_BIT]) begin
         lock_state_q <= SDRC_SEARCH;
         lock_run_q <= 3'h0;
      end else if (pfd_tick_q) begin
         case (lock_state_q)
            SDRC_SEARCH: begin
               if (PHASE_ERR_NS >= LOCK_SET_NS) begin
                  lock_run_q <= 3'h0;
               end else if (lock_run_q == LOCK_RUN - 3'h1) begin
                  lock_run_q <= 3'h0;
                  lock_state_q <= SDRC_LOCKED;
               end else begin
                  lock_run_q <= lock_run_q + 3'h1;
               end
            end
            SDRC_LOCKED: begin
               if (PHASE_ERR_NS >= LOCK_CLEAR_NS) begin
                  lock_state_q <= SDRC_SEARCH;
               end
            end
            default: begin
               lock_state_q <= SDRC_SEARCH;
            end
         endcase
      end
   end

   // Diagnostic multiplexer; registered so the pin never glitches on a setting change.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         mux_q <= 1'b0;
      end else begin
         case (latch_q[0][R0_MUX_LSB +: 3])
            MUX_REG_READY: mux_q <= reg_ready_q;
            MUX_DIG_LOCK: mux_q <= (lock_state_q == SDRC_LOCKED);
            MUX_PLL_EN: mux_q <= latch_q[0][R0_PLL_EN_BIT];
            MUX_PFD_TICK: mux_q <= pfd_tick_q;
            MUX_LOGIC_HIGH: mux_q <= 1'b1;
            default: mux_q <= 1'b0;
         endcase
      end
   end

   // Register port read; data stand only in the cycle after the strobe.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         rdata_q <= 32'h0000_0000;
      end else if (!RD) begin
         rdata_q <= 32'h0000_0000;
      end else if (ADDR == ADDR_LATCH0) begin
         rdata_q <= latch_q[0];
      end else if (ADDR == ADDR_LATCH1) begin
         rdata_q <= latch_q[1];
      end else if (ADDR == ADDR_STATUS) begin
         rdata_q <= {29'h0000_0000, div_bus.drive, lock_state_q == SDRC_LOCKED, reg_ready_q};
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end

   // Divide field k gives a ratio of 2k; it is forced to zero while the oscillator is off.
   assign div_bus.div_k = osc_en_q ? latch_q[1][R1_CLKDIV_LSB +: 4] : 4'h0;

   sdrc_clkdiv u_clkdiv (
      .clk(CLOCK),
      .rst(RST),
      .port(div_bus.div)
   );

   assign RDATA = rdata_q;
   assign REGULATOR_ENABLE = POWER_ON;
   assign OSC_ENABLE = osc_en_q;
   assign DIVIDED_REF_CLOCK_OUT = div_bus.clk_level;
   assign DIVIDED_REF_CLOCK_OE = div_bus.drive;
   assign DIAG_MUX_OUT = mux_q;
   assign PLL_ENABLE = latch_q[0][R0_PLL_EN_BIT];
   assign VCO_ENABLE = latch_q[0][R0_PLL_EN_BIT];
   assign VCO_ADJUST = latch_q[1][R1_VADJ_LSB +: 2];
   assign VCO_BIAS = latch_q[1][R1_BIAS_LSB +: 4];
   assign LOW_BAND_DIV2 = latch_q[1][R1_DIV2_BIT];
   assign INT_DIVIDE = latch_q[0][R0_INT_LSB +: 8];
   assign FRAC_DIVIDE = latch_q[0][R0_FRAC_LSB +: 14];
   assign PFD_TICK = pfd_tick_q;
   assign FEEDBACK_DIVIDE = fb_div_q;

   // Named steps of a lock acquisition and a lock loss.
   sequence good_cmp_s;
      pfd_tick_q && PHASE_ERR_NS < LOCK_SET_NS && latch_q[0][R0_PLL_EN_BIT];
   endsequence

   sequence bad_cmp_s;
      pfd_tick_q && PHASE_ERR_NS >= LOCK_CLEAR_NS && latch_q[0][R0_PLL_EN_BIT];
   endsequence

   // Lock can only be entered on a good comparison with four good ones before it.
   lock_set_a: assert property (@(posedge CLOCK) disable iff (RST)
      $rose(lock_state_q == SDRC_LOCKED) |->
      $past(pfd_tick_q && PHASE_ERR_NS < LOCK_SET_NS && lock_run_q == 3'h4))
      else $error("Lock set without five good comparisons.");

   // The fifth good comparison in a row always sets the lock on the next edge.
   lock_enter_a: assert property (@(posedge CLOCK) disable iff (RST)
      (good_cmp_s and (lock_state_q == SDRC_SEARCH && lock_run_q == LOCK_RUN - 3'h1)) |=>
      lock_state_q == SDRC_LOCKED)
      else $error("Lock not set after five good comparisons.");

   // A large error while locked drops the lock on the next edge.
   lock_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
      ((lock_state_q == SDRC_LOCKED) and bad_cmp_s) |=> lock_state_q == SDRC_SEARCH)
      else $error("Lock not cleared after a large error.");

   // Lock holds through small and medium errors.
   lock_hold_a: assert property (@(posedge CLOCK) disable iff (RST)
      (lock_state_q == SDRC_LOCKED && latch_q[0][R0_PLL_EN_BIT] && POWER_ON &&
      !(pfd_tick_q && PHASE_ERR_NS >= LOCK_CLEAR_NS)) |=> lock_state_q == SDRC_LOCKED)
      else $error("Lock dropped without a large error.");

   // Power pin low restores every latch to its default in one edge.
   power_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
      (!POWER_ON) |=> (latch_q[0] == R0_RESET && latch_q[1] == R1_RESET && !reg_ready_q))
      else $error("Settings survived power pin low.");

   // Oscillator follows bit 12 and the power pin one edge later.
   osc_enable_a: assert property (@(posedge CLOCK) disable iff (RST)
      1'b1 |=> OSC_ENABLE == ($past(POWER_ON) && $past(latch_q[1][R1_OSC_EN_BIT])))
      else $error("Oscillator enable wrong.");

   // Regulator ready rises exactly after the start-up count of powered cycles.
   reg_ready_a: assert property (@(posedge CLOCK) disable iff (RST)
      $rose(reg_ready_q) |-> $past(reg_cnt_q) == REG_UP_COUNT - 12'h001 && $past(POWER_ON))
      else $error("Regulator ready at the wrong time.");

   // Mux on the lock source mirrors the lock flag one edge later.
   mux_lock_a: assert property (@(posedge CLOCK) disable iff (RST)
      (latch_q[0][R0_MUX_LSB +: 3] == MUX_DIG_LOCK) |=> DIAG_MUX_OUT == $past(lock_state_q == SDRC_LOCKED))
      else $error("Mux lock source mismatch.");

   // Mux on the default source mirrors regulator ready one edge later.
   mux_reg_a: assert property (@(posedge CLOCK) disable iff (RST)
      (latch_q[0][R0_MUX_LSB +: 3] == MUX_REG_READY) |=> DIAG_MUX_OUT == $past(reg_ready_q))
      else $error("Mux regulator source mismatch.");

   // Strobe rise with latch code 1 loads the shift word into latch 1.
   latch_load_a: assert property (@(posedge CLOCK) disable iff (RST)
      (POWER_ON && reg_ready_q && strobe_rise && shift_q[1:0] == ADDR_LATCH1) |=> latch_q[1] == $past(shift_q))
      else $error("Latch not loaded on strobe.");

   // With R = 2, phase detector ticks are spaced by exactly two cycles.
   pfd_spacing_a: assert property (@(posedge CLOCK) disable iff (RST)
      (pfd_tick_q && r_div == 3'h2 && osc_en_q) ##1 (osc_en_q && r_div == 3'h2) |-> !pfd_tick_q ##1 pfd_tick_q)
      else $error("Reference divider spacing wrong.");

endmodule

// ---- sim/sdrc_host.sv ----
// Host model that builds latch words and shifts them into the serial port.
`timescale 1ns/1ps
module sdrc_host (
   input wire logic CLOCK,
   input wire logic POWER_ON,
   input wire logic READY_IN,
   output logic SCLK,
   output logic SDATA,
   output logic STROBE
);
   logic seen_q; // Set once regulator ready has been seen since power came up.

   initial begin
      SCLK = 1'b0;
      SDATA = 1'b0;
      STROBE = 1'b0;
      seen_q = 1'b0;
   end

   // Remember regulator ready; a power drop forgets it, so the host waits again.
   always @(posedge CLOCK) begin
      if (!POWER_ON) begin
         seen_q <= 1'b0;
      end else if (READY_IN) begin
         seen_q <= 1'b1;
      end
   end

   // Latch 0 word; the integer part is kept inside the pulse-swallow range.
   function automatic logic [31:0] w0(input logic [2:0] mux, input logic pll, input int n, input logic [13:0] f);
      logic [7:0] i;
      i = (n < 31) ? 8'h1F : (n > 255) ? 8'hFF : 8'(n);
      return {mux, pll, 4'h0, i, f, 2'h0};
   endfunction

   // Latch 1 word; the bias never drops below the oscillation floor.
   function automatic logic [31:0] w1(input logic [1:0] adj, input logic [3:0] bias, input logic d2, input logic osc,
      input logic [3:0] k, input logic [2:0] r);
      logic [3:0] b;
      b = (bias < 4'hC) ? 4'hC : bias;
      return {10'h000, adj, b, 2'h0, d2, osc, k, 1'b0, r, 4'h1};
   endfunction

   // Shift one word MSB first, then pulse the load strobe. Data is scrambled after release
   // so a stale bit never looks valid.
   task automatic send(input logic [31:0] w);
      wait (seen_q);
      for (int i = 31; i >= 0; i--) begin
         @(posedge CLOCK);
         SCLK <= 1'b0;
         SDATA <= w[i];
         @(posedge CLOCK);
         SCLK <= 1'b1;
      end
      @(posedge CLOCK);
      SCLK <= 1'b0;
      STROBE <= 1'b1;
      @(posedge CLOCK);
      STROBE <= 1'b0;
      SDATA <= ~SDATA;
   endtask
endmodule

// ---- sim/testbench.sv ----
// Self-checking testbench for the synthesizer reference and divider control block.
`timescale 1ns/1ps
module testbench;
   import sdrc_pkg::*;
   logic CLOCK, RST, POWER_ON, SCLK, SDATA, LATCH_LOAD_STROBE, WR, RD;
   logic [7:0] PHASE_ERR_NS;
   logic [1:0] ADDR;
   logic [31:0] WDATA, RDATA;
   logic REGULATOR_ENABLE, OSC_ENABLE, DIVIDED_REF_CLOCK_OUT, DIVIDED_REF_CLOCK_OE, DIAG_MUX_OUT;
   logic PLL_ENABLE, VCO_ENABLE, LOW_BAND_DIV2, PFD_TICK;
   logic [1:0] VCO_ADJUST;
   logic [3:0] VCO_BIAS;
   logic [7:0] INT_DIVIDE;
   logic [13:0] FRAC_DIVIDE;
   logic [8:0] FEEDBACK_DIVIDE;
   int n_fail = 0; // Mismatches seen.
   int checks_done = 0; // Comparisons made.

   sdrc_top u_dut (.CLOCK(CLOCK), .RST(RST), .POWER_ON(POWER_ON), .SCLK(SCLK), .SDATA(SDATA),
      .LATCH_LOAD_STROBE(LATCH_LOAD_STROBE), .PHASE_ERR_NS(PHASE_ERR_NS), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .REGULATOR_ENABLE(REGULATOR_ENABLE), .OSC_ENABLE(OSC_ENABLE),
      .DIVIDED_REF_CLOCK_OUT(DIVIDED_REF_CLOCK_OUT), .DIVIDED_REF_CLOCK_OE(DIVIDED_REF_CLOCK_OE),
      .DIAG_MUX_OUT(DIAG_MUX_OUT), .PLL_ENABLE(PLL_ENABLE), .VCO_ENABLE(VCO_ENABLE), .VCO_ADJUST(VCO_ADJUST),
      .VCO_BIAS(VCO_BIAS), .LOW_BAND_DIV2(LOW_BAND_DIV2), .INT_DIVIDE(INT_DIVIDE), .FRAC_DIVIDE(FRAC_DIVIDE),
      .PFD_TICK(PFD_TICK), .FEEDBACK_DIVIDE(FEEDBACK_DIVIDE));
   sdrc_host u_host (.CLOCK(CLOCK), .POWER_ON(POWER_ON), .READY_IN(DIAG_MUX_OUT), .SCLK(SCLK), .SDATA(SDATA),
      .STROBE(LATCH_LOAD_STROBE));

   // Free-running 50 MHz reference.
   always #10 CLOCK = ~CLOCK;

   // Compare one value and report at once on a mismatch.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run.
   task automatic results();
      if (n_fail == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // One-cycle register write and read; read data stands only in the cycle after the strobe.
   task automatic wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge CLOCK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLOCK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [31:0] d);
      @(posedge CLOCK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask

   // Measure two successive half periods of the clock output after a fresh edge.
   task automatic half(input int exp);
      logic v;
      int n;
      v = DIVIDED_REF_CLOCK_OUT;
      do @(posedge CLOCK); while (DIVIDED_REF_CLOCK_OUT === v);
      repeat (2) begin
         v = DIVIDED_REF_CLOCK_OUT;
         n = 0;
         do begin @(posedge CLOCK); n++; end while (DIVIDED_REF_CLOCK_OUT === v);
         chk(n, exp);
      end
   endtask

   // Count cycles between two detector ticks, or wait for a number of ticks.
   task automatic gap(input int exp);
      int n;
      do @(posedge CLOCK); while (PFD_TICK !== 1'b1);
      n = 0;
      do begin @(posedge CLOCK); n++; end while (PFD_TICK !== 1'b1);
      chk(n, exp);
   endtask
   task automatic ticks(input int t);
      repeat (t) do @(posedge CLOCK); while (PFD_TICK !== 1'b1);
      repeat (3) @(posedge CLOCK);
   endtask

   // Power-up defaults, writes refused before ready, then regulator ready on the mux.
   task automatic t_defaults();
      logic [31:0] d;
      int i;
      repeat (3) @(posedge CLOCK);
      chk(OSC_ENABLE, 1);
      chk(DIVIDED_REF_CLOCK_OE, 1);
      wr(ADDR_LATCH0, 32'h1000_0000);
      repeat (2) @(posedge CLOCK);
      chk(PLL_ENABLE, 0);
      for (i = 0; i < 3000 && DIAG_MUX_OUT !== 1'b1; i++) @(posedge CLOCK);
      chk(DIAG_MUX_OUT, 1);
      rd(ADDR_STATUS, d);
      chk(d[ST_REG_READY], 1);
      rd(2'h3, d);
      chk(d, 0);
      half(4);
   endtask

   // Divide field extremes, stop, and the R divider.
   task automatic t_divs();
      logic [31:0] d;
      wr(ADDR_LATCH1, u_host.w1(0, 12, 0, 1, 15, 2));
      rd(ADDR_LATCH1, d);
      chk(d, u_host.w1(0, 12, 0, 1, 15, 2));
      half(15);
      gap(2);
      wr(ADDR_LATCH1, u_host.w1(0, 12, 0, 1, 1, 3));
      half(1);
      gap(3);
      wr(ADDR_LATCH1, u_host.w1(0, 12, 0, 1, 0, 7));
      repeat (3) @(posedge CLOCK);
      chk(DIVIDED_REF_CLOCK_OE, 0);
      gap(7);
   endtask

   // Serial load of latch 0, then lock set after five good ticks and cleared by a large error.
   task automatic t_lock();
      u_host.send(u_host.w0(MUX_DIG_LOCK, 1, 100, 14'h3FFF));
      repeat (2) @(posedge CLOCK);
      chk({PLL_ENABLE, VCO_ENABLE}, 2'h3);
      chk({INT_DIVIDE, FRAC_DIVIDE}, {8'h64, 14'h3FFF});
      PHASE_ERR_NS <= 8'h0E;
      ticks(4);
      chk(DIAG_MUX_OUT, 0);
      chk(FEEDBACK_DIVIDE, 9'h065);
      ticks(1);
      chk(DIAG_MUX_OUT, 1);
      PHASE_ERR_NS <= 8'h18;
      ticks(2);
      chk(DIAG_MUX_OUT, 1);
      PHASE_ERR_NS <= 8'h19;
      ticks(1);
      chk(DIAG_MUX_OUT, 0);
   endtask

   // VCO fields, mux sources, and the external reference setting.
   task automatic t_vco_mux();
      logic [2:0] codes [3] = '{MUX_LOGIC_HIGH, MUX_LOGIC_LOW, MUX_PLL_EN};
      for (int i = 0; i < 2; i++) begin
         u_host.send(u_host.w1(2'(3 * i), 10, 1'(i), 1, 4, 7));
         repeat (2) @(posedge CLOCK);
         chk({VCO_ADJUST, LOW_BAND_DIV2, VCO_BIAS}, {2'(3 * i), 1'(i), 4'hC});
      end
      foreach (codes[i]) begin
         u_host.send(u_host.w0(codes[i], 1, 100, 0));
         repeat (3) @(posedge CLOCK);
         chk(DIAG_MUX_OUT, codes[i] != MUX_LOGIC_LOW);
      end
      u_host.send(u_host.w1(0, 12, 1, 0, 4, 7));
      repeat (3) @(posedge CLOCK);
      chk({OSC_ENABLE, DIVIDED_REF_CLOCK_OE}, 2'h0);
   endtask

   // Power pin low drops the regulators and restores every setting.
   task automatic t_power();
      POWER_ON <= 1'b0;
      repeat (3) @(posedge CLOCK);
      chk({REGULATOR_ENABLE, OSC_ENABLE}, 2'h0);
      POWER_ON <= 1'b1;
      repeat (3) @(posedge CLOCK);
      chk({PLL_ENABLE, LOW_BAND_DIV2, OSC_ENABLE, DIAG_MUX_OUT}, 4'h2);
   endtask

   // Main sequence.
   initial begin
      CLOCK = 1'b0;
      RST = 1'b1;
      POWER_ON = 1'b1;
      PHASE_ERR_NS = 8'h28;
      ADDR = 2'h0;
      WDATA = 32'h0;
      WR = 1'b0;
      RD = 1'b0;
      repeat (4) @(posedge CLOCK);
      RST <= 1'b0;
      t_defaults();
      t_divs();
      t_lock();
      t_vco_mux();
      t_power();
      results();
   end

   // Watchdog well beyond the expected run of about 3000 cycles.
   initial begin
      #400000;
      n_fail++;
      results();
   end
endmodule
